// >>> verification/nps_host_model.sv
// Pull-up model of the host side of the open-drain lines
`timescale 1ns/1ns
module nps_host_model
(
   // Open-drain pins
   input  wire logic rst_out,
   input  wire logic rst_oe,
   input  wire logic flg_out,
   input  wire logic flg_oe,
   // Resolved lines
   output      logic rst_ln,
   output      logic flg_ln
);
   assign rst_ln = rst_oe ? rst_out : 1'b1;
   assign flg_ln = flg_oe ? flg_out : 1'b1;
endmodule : nps_host_model

// >>> verification/nps_supervisor_properties.sv
// Port checks for the NVRAM power supervisor
`timescale 1ns/1ns
module nps_supervisor_properties
   import nps_pkg::*;
#(
   parameter logic [REC_W-1:0] CER_COUNT   = 22'h14,
   parameter logic [REC_W-1:0] REC_COUNT   = 22'h1E,
   parameter logic [CHK_W-1:0] CHECK_COUNT = 42'h32
)
(
   // Clock, reset and inputs
   input wire logic             SYS_CLK,
   input wire logic             RST_N,
   input wire logic             CHIP_SELECT_N,
   input wire logic [SEL_W-1:0] SELECT_CODE,
   input wire logic             THRESHOLD_CHOICE,
   input wire logic             SUPPLY_BELOW_STD_THRESHOLD,
   input wire logic             SUPPLY_BELOW_ALT_THRESHOLD,
   input wire logic             SUPPLY_BELOW_MIN_THRESHOLD,
   input wire logic             BATTERY_BELOW_LIMIT,
   // Outputs
   input wire logic [3:0]       CONDITIONED_SRAM_SELECTS_N,
   input wire logic             RESET_N_OUT,
   input wire logic             RESET_N_OE,
   input wire logic             BATTERY_LOW_FLAG_N_OUT,
   input wire logic             BATTERY_LOW_FLAG_N_OE
);
   logic             fail;
   logic [REC_W-1:0] good_q;
   assign fail = SUPPLY_BELOW_MIN_THRESHOLD | (THRESHOLD_CHOICE ?
      SUPPLY_BELOW_ALT_THRESHOLD : SUPPLY_BELOW_STD_THRESHOLD);
   // Edges since the supply last read failing
   always_ff @(posedge SYS_CLK or negedge RST_N)
      if (!RST_N)
         good_q <= '0;
      else
         good_q <= fail ? '0 : good_q + REC_W'(1);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence idle_fail_s;
      fail && CHIP_SELECT_N;
   endsequence
   decode_follow_a: assert property (!fail && good_q > CER_COUNT + 3 |=>
      CONDITIONED_SRAM_SELECTS_N == ($past(CHIP_SELECT_N) ? 4'hF
      : ~(4'h1 << $past(SELECT_CODE)))) else $error("decode wrong");
   fail_deselect_a: assert property (idle_fail_s ##1 idle_fail_s |=>
      CONDITIONED_SRAM_SELECTS_N == 4'hF) else $error("fail select");
   min_deselect_a: assert property (SUPPLY_BELOW_MIN_THRESHOLD [*2] |=>
      CONDITIONED_SRAM_SELECTS_N == 4'hF) else $error("min select");
   cer_hold_a: assert property (good_q > 0 && good_q < CER_COUNT |->
      CONDITIONED_SRAM_SELECTS_N == 4'hF) else $error("early select");
   reset_assert_a: assert property (fail |=> RESET_N_OE)
      else $error("reset not low");
   rec_hold_a: assert property (good_q < REC_COUNT |-> RESET_N_OE)
      else $error("reset early");
   open_drain_a: assert property (
      !RESET_N_OUT && !BATTERY_LOW_FLAG_N_OUT) else $error("drive high");
   flag_update_a: assert property ($changed(BATTERY_LOW_FLAG_N_OE)
      |-> !$past(fail) && BATTERY_LOW_FLAG_N_OE == $past(BATTERY_BELOW_LIMIT))
      else $error("flag change");
endmodule : nps_supervisor_properties

// >>> verification/test_nps_supervisor.sv
// Self-checking bench for the NVRAM power supervisor
`timescale 1ns/1ns
module test_nps_supervisor
   import nps_pkg::*;
;
   localparam logic [REC_W-1:0] REC = 22'h1E;
   localparam logic [CHK_W-1:0] CHK = 42'h32;
   logic        clk  = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs_n = 1'b1;
   logic [1:0]  code = 2'h0;
   logic        thr  = 1'b0;
   logic        std  = 1'b0;
   logic        alt  = 1'b0;
   logic        mn   = 1'b0;
   logic        bat  = 1'b1;
   logic [3:0]  sel_n;
   logic        rst_o, rst_oe, flg_o, flg_oe, rst_ln, flg_ln;
   logic [31:0] lfsr = 32'h16588031;
   int          err_total = 0;
   int          compares = 0;
   int          cycles = 0;
   nps_supervisor #(.CER_COUNT(22'h14), .REC_COUNT(REC), .CHECK_COUNT(CHK))
   i_nps_supervisor (.SYS_CLK(clk), .RST_N(rst_n), .CHIP_SELECT_N(cs_n),
      .SELECT_CODE(code), .THRESHOLD_CHOICE(thr),
      .SUPPLY_BELOW_STD_THRESHOLD(std), .SUPPLY_BELOW_ALT_THRESHOLD(alt),
      .SUPPLY_BELOW_MIN_THRESHOLD(mn), .BATTERY_BELOW_LIMIT(bat),
      .CONDITIONED_SRAM_SELECTS_N(sel_n), .RESET_N_OUT(rst_o),
      .RESET_N_OE(rst_oe), .BATTERY_LOW_FLAG_N_OUT(flg_o),
      .BATTERY_LOW_FLAG_N_OE(flg_oe));
   nps_host_model i_nps_host_model (.rst_out(rst_o), .rst_oe(rst_oe),
      .flg_out(flg_o), .flg_oe(flg_oe), .rst_ln(rst_ln), .flg_ln(flg_ln));
   always #20 clk = ~clk;
   function automatic logic [31:0] nps_lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nps_lfsr
   function automatic logic [3:0] exp_sel(input logic c, input logic [1:0] a);
      return c ? 4'hF : ~(4'h1 << a);
   endfunction : exp_sel
   task close_out();
      $display("Compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   task chk(input string what, input logic [3:0] e, input logic [3:0] s);
      compares++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", what, e, s);
         err_total++;
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task wait_on(input logic pick, input logic lvl, output int n);
      n = 0;
      while (((pick ? flg_ln : rst_ln) !== lvl) && n < 300)
      begin
         cyc(1);
         n++;
      end
   endtask : wait_on
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         err_total++;
         close_out();
      end
   end
   initial
   begin
      int n;
      cyc(6);
      rst_n = 1'b1;
      wait_on(1'b0, 1'b1, n);
      chk("rec", 4'h1, {3'h0, n >= REC && n <= REC + 5});
      chk("upflag", 4'h0, {3'h0, flg_ln});
      for (int i = 0; i < 44; i++)
      begin
         lfsr = nps_lfsr(lfsr);
         cs_n = (i < 4) ? 1'b0 : lfsr[0];
         code = (i < 4) ? 2'(i) : lfsr[2:1];
         cyc(1);
         chk("decode", cs_n ? 4'hF : ~(4'h1 << code), sel_n);
      end
      bat = 1'b0;
      wait_on(1'b1, 1'b1, n);
      bat = 1'b1;
      wait_on(1'b1, 1'b0, n);
      chk("period", 4'h1, {3'h0, n >= CHK && n <= CHK + 2});
      bat = 1'b0;
      cs_n = 1'b0;
      code = 2'h1;
      cyc(10);
      chk("hold", 4'h0, {3'h0, flg_ln});
      std = 1'b1;
      cyc(1);
      chk("rstlow", 4'h0, {3'h0, rst_ln});
      cyc(3);
      chk("drain", 4'hD, sel_n);
      cs_n = 1'b1;
      cyc(2);
      chk("desel", 4'hF, sel_n);
      mn = 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         lfsr = nps_lfsr(lfsr);
         {cs_n, code} = lfsr[2:0];
         cyc(1);
         chk("min", 4'hF, sel_n);
      end
      chk("nochk", 4'h0, {3'h0, flg_ln});
      mn = 1'b0;
      thr = 1'b1;
      cs_n = 1'b0;
      cyc(3);
      chk("cer", 4'hF, sel_n);
      wait_on(1'b0, 1'b1, n);
      chk("recalt", 4'h1, {3'h0, n >= REC - 3 && n <= REC + 5});
      chk("uppass", 4'h1, {3'h0, flg_ln});
      chk("after", ~(4'h1 << code), sel_n);
      alt = 1'b1;
      cyc(1);
      chk("rstalt", 4'h0, {3'h0, rst_ln});
      cyc(WPT_CYCLES);
      chk("wptheld", exp_sel(1'b0, code), sel_n);
      cyc(1);
      chk("wptcut", 4'hF, sel_n);
      close_out();
   end
endmodule : test_nps_supervisor
bind nps_supervisor nps_supervisor_properties #(.CER_COUNT(CER_COUNT),
   .REC_COUNT(REC_COUNT), .CHECK_COUNT(CHECK_COUNT))
   i_nps_supervisor_properties (.SYS_CLK, .RST_N, .CHIP_SELECT_N,
   .SELECT_CODE, .THRESHOLD_CHOICE, .SUPPLY_BELOW_STD_THRESHOLD,
   .SUPPLY_BELOW_ALT_THRESHOLD, .SUPPLY_BELOW_MIN_THRESHOLD,
   .BATTERY_BELOW_LIMIT, .CONDITIONED_SRAM_SELECTS_N, .RESET_N_OUT,
   .RESET_N_OE, .BATTERY_LOW_FLAG_N_OUT, .BATTERY_LOW_FLAG_N_OE);

// >>> verilog/nps_pkg.sv
// Constants and types for the NVRAM power supervisor
package nps_pkg;

   localparam int     CLK_MHZ      = 25;
   localparam longint CLK_HZ       = 64'd25_000_000;

   // Write-protect interval, longest time, microseconds
   localparam int     WPT_US       = 150;
   localparam int     WPT_CYCLES   = WPT_US * CLK_MHZ;
   localparam int     WPT_W        = 12;

   // Enable and reset recovery intervals, milliseconds
   localparam int     CER_MS       = 120;
   localparam int     REC_MS       = 120;
   localparam longint MS_PER_S     = 64'd1000;
   localparam longint CER_CYCLES   = longint'(CER_MS) * CLK_HZ / MS_PER_S;
   localparam longint REC_CYCLES   = longint'(REC_MS) * CLK_HZ / MS_PER_S;
   localparam int     REC_W        = 22;

   // Battery check period, hours
   localparam int     CHECK_HOURS  = 24;
   localparam longint S_PER_HOUR   = 64'd3600;
   localparam longint CHECK_CYCLES = longint'(CHECK_HOURS) * S_PER_HOUR
                                     * CLK_HZ;
   localparam int     CHK_W        = 42;

   localparam int     NUM_SELECTS  = 4;
   localparam int     SEL_W        = 2;
   localparam logic [NUM_SELECTS-1:0] SELECTS_IDLE = 4'hF;
   localparam logic [NUM_SELECTS-1:0] SELECT_ONE   = 4'h1;

   typedef enum logic [1:0] {
      NPS_RUN,
      NPS_DRAIN,
      NPS_DOWN,
      NPS_RECOVER
   } nps_state_e;

endpackage : nps_pkg

// >>> verilog/nps_supervisor.sv
// NVRAM power supervisor: enable conditioning, reset and battery flag
// Functional notes
// R1: Chip-select high drives all enables high; low, selects pick one.
// R2: Below threshold all enables inactive; an access in progress completes. The code holds it at most WPT_CYCLES + 1 cycles, and cuts it at once in NPS_RECOVER.
// R3: After supply returns, enables stay inactive for the recovery interval.
// R4: Below minimum threshold, select inputs are ignored; enables inactive.
// R5: Reset output goes low within write-protect interval of a power fail.
// R6: After supply returns, a timer holds reset low for recovery interval.
// R7: Reset is open-drain: only pulled low or released.
// R8: Battery checked at each power-up and every check period thereafter.
// R9: A check finding battery below limit asserts the low-battery flag.
// R10: Flag stays asserted until a later check passes.
// R11: Battery checks occur only with nominal supply present.
// R12: Low-battery flag is open-drain: pulled low or released.
// R13: Comparator results are synchronous inputs; timer limits are parameters, except the write-protect limit, fixed from WPT_CYCLES.
`timescale 1ns/1ns
module nps_supervisor
   import nps_pkg::*;
#(
   parameter logic [REC_W-1:0] CER_COUNT   = REC_W'(CER_CYCLES),
   parameter logic [REC_W-1:0] REC_COUNT   = REC_W'(REC_CYCLES),
   parameter logic [CHK_W-1:0] CHECK_COUNT = CHK_W'(CHECK_CYCLES)
)
(
   // Clock and reset
   input  wire logic                   SYS_CLK,
   input  wire logic                   RST_N,
   // Host selects
   input  wire logic                   CHIP_SELECT_N,
   input  wire logic [SEL_W-1:0]       SELECT_CODE,
   // Comparator decisions
   input  wire logic                   THRESHOLD_CHOICE,
   input  wire logic                   SUPPLY_BELOW_STD_THRESHOLD,
   input  wire logic                   SUPPLY_BELOW_ALT_THRESHOLD,
   input  wire logic                   SUPPLY_BELOW_MIN_THRESHOLD,
   input  wire logic                   BATTERY_BELOW_LIMIT,
   // Conditioned SRAM enables
   output      logic [NUM_SELECTS-1:0] CONDITIONED_SRAM_SELECTS_N,
   // Open-drain power-on reset
   output      logic                   RESET_N_OUT,
   output      logic                   RESET_N_OE,
   // Open-drain low-battery flag
   output      logic                   BATTERY_LOW_FLAG_N_OUT,
   output      logic                   BATTERY_LOW_FLAG_N_OE
);

   localparam logic [REC_W-1:0] REC_LIMIT =
      (CER_COUNT > REC_COUNT) ? CER_COUNT : REC_COUNT;
   localparam logic [WPT_W-1:0] WPT_LIMIT = WPT_W'(WPT_CYCLES);

   typedef struct packed {
      nps_state_e             state;
      logic [NUM_SELECTS-1:0] sel_n;
      logic                   rst_oe;
      logic                   bl_oe;
      logic                   od_low;
   } nps_state_s;

   nps_state_s st_q;
   nps_state_s st_d;

   logic             power_fail;
   logic [REC_W-1:0] rec_count;
   logic             rec_done;
   logic             wpt_done;
   logic             chk_done;

   // Host decode: one enable low per select code
   function automatic logic [NUM_SELECTS-1:0] decode_selects
   (
      input logic             cs_n,
      input logic [SEL_W-1:0] code
   );
      logic [NUM_SELECTS-1:0] res;
      res = SELECTS_IDLE;
      if (!cs_n)
      begin
         res = ~(SELECT_ONE << code);
      end
      return res;
   endfunction : decode_selects

   // Threshold chosen by the strap-level input
   assign power_fail = THRESHOLD_CHOICE ? SUPPLY_BELOW_ALT_THRESHOLD
                                        : SUPPLY_BELOW_STD_THRESHOLD; // R13

   nps_timer #(.W(WPT_W)) u_wpt_timer
   (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .clear (st_q.state != NPS_DRAIN),
      .run   (1'b1),
      .limit (WPT_LIMIT),
      .count (),
      .done  (wpt_done)
   );

   nps_timer #(.W(REC_W)) u_rec_timer
   (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .clear (st_q.state != NPS_RECOVER),
      .run   (1'b1),
      .limit (REC_LIMIT),
      .count (rec_count),
      .done  (rec_done)
   ); // R13

   nps_timer #(.W(CHK_W)) u_chk_timer
   (
      .clk   (SYS_CLK),
      .rst_n (RST_N),
      .clear ((st_q.state != NPS_RUN) || chk_done),
      .run   (1'b1),
      .limit (CHECK_COUNT),
      .count (),
      .done  (chk_done)
   ); // R13

   always_comb
   begin
      st_d        = st_q;
      st_d.od_low = 1'b0; // R7 R12
      unique case (st_q.state)
         NPS_RUN:
         begin
            st_d.rst_oe = 1'b0;
            st_d.sel_n  = decode_selects(CHIP_SELECT_N, SELECT_CODE); // R1
            if (chk_done && !power_fail && !SUPPLY_BELOW_MIN_THRESHOLD)
            begin
               st_d.bl_oe = BATTERY_BELOW_LIMIT; // R8 R9 R10 R11
            end
            if (SUPPLY_BELOW_MIN_THRESHOLD)
            begin
               st_d.state  = NPS_DOWN;
               st_d.sel_n  = SELECTS_IDLE; // R4
               st_d.rst_oe = 1'b1; // R5
            end
            else if (power_fail)
            begin
               st_d.rst_oe = 1'b1; // R5
               if (!CHIP_SELECT_N && (st_q.sel_n != SELECTS_IDLE))
               begin
                  st_d.state = NPS_DRAIN;
                  st_d.sel_n = st_q.sel_n; // R2
               end
               else
               begin
                  st_d.state = NPS_DOWN;
                  st_d.sel_n = SELECTS_IDLE; // R2
               end
            end
         end
         NPS_DRAIN:
         begin
            st_d.rst_oe = 1'b1; // R5
            if (CHIP_SELECT_N || wpt_done || SUPPLY_BELOW_MIN_THRESHOLD)
            begin
               st_d.state = NPS_DOWN;
               st_d.sel_n = SELECTS_IDLE; // R2 R4
            end
         end
         NPS_DOWN:
         begin
            st_d.rst_oe = 1'b1;
            st_d.sel_n  = SELECTS_IDLE; // R2 R4
            if (!power_fail && !SUPPLY_BELOW_MIN_THRESHOLD)
            begin
               st_d.state = NPS_RECOVER;
            end
         end
         NPS_RECOVER:
         begin
            st_d.sel_n  = SELECTS_IDLE; // R3
            st_d.rst_oe = 1'b1; // R6
            if (power_fail || SUPPLY_BELOW_MIN_THRESHOLD)
            begin
               st_d.state = NPS_DOWN;
            end
            else
            begin
               if (rec_count >= CER_COUNT)
               begin
                  st_d.sel_n = decode_selects(CHIP_SELECT_N,
                                              SELECT_CODE); // R3 R1
               end
               if (rec_count >= REC_COUNT)
               begin
                  st_d.rst_oe = 1'b0; // R6
               end
               if (rec_done)
               begin
                  st_d.state = NPS_RUN;
                  st_d.bl_oe = BATTERY_BELOW_LIMIT; // R8 R9 R10 R11
               end
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_q.state  <= NPS_DOWN;
         st_q.sel_n  <= SELECTS_IDLE;
         st_q.rst_oe <= 1'b1;
         st_q.bl_oe  <= 1'b0;
         st_q.od_low <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign CONDITIONED_SRAM_SELECTS_N = st_q.sel_n;
   assign RESET_N_OUT                = st_q.od_low; // R7
   assign RESET_N_OE                 = st_q.rst_oe; // R7
   assign BATTERY_LOW_FLAG_N_OUT     = st_q.od_low; // R12
   assign BATTERY_LOW_FLAG_N_OE      = st_q.bl_oe; // R12

endmodule : nps_supervisor

// >>> verilog/nps_timer.sv
// Saturating interval counter with clear and run controls
`timescale 1ns/1ns
module nps_timer
   import nps_pkg::*;
#(
   parameter int W = 8
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         clear,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   // Status
   output      logic [W-1:0] count,
   output      logic         done
);

   typedef struct packed {
      logic [W-1:0] count;
   } nps_tmr_s;

   nps_tmr_s st_q;
   nps_tmr_s st_d;

   always_comb
   begin
      st_d = st_q;
      if (clear)
      begin
         st_d.count = '0;
      end
      else if (run && (st_q.count < limit))
      begin
         st_d.count = st_q.count + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign count = st_q.count;
   assign done  = (st_q.count >= limit);

endmodule : nps_timer
